// ### testbench.sv
// self-checking bench for the asynchronous serial receiver
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import uarx_pkg::*;
    logic clock;
    logic sys_rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxd;
    logic irq;
    logic [31:0] rdv;
    logic errv;
    int miscompares;
    int compares;
    int i;
    // divisor 1 at high speed gives 2 clocks a tick; divisor 0 at low speed 4
    localparam int BIT_HI = 32;
    localparam int BIT_LO = 64;
    localparam logic [11:0] RST_OFFS [5] = '{UARX_OFF_CTRL, UARX_OFF_DIV,
        UARX_OFF_IRQ_FLAG, UARX_OFF_IRQ_EN, UARX_OFF_CORE};
    uarx_top u_uarx_top (.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RXD(rxd), .IRQ(irq));
    uarx_tx_model u_uarx_tx_model (.clk(clock), .line(rxd));
    // ****
    // clock and helpers
    // ****
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        begin
            compares++;
            if (seen !== exp)
            begin
                miscompares++;
                $display("wrong value %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task automatic final_report();
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        begin
            @(posedge clock);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wd;
            @(posedge clock);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge clock);
                n++;
            end
            while (pready !== 1'b1 && n < 50);
            if (pready !== 1'b1)
            begin
                miscompares++;
                final_report();
            end
            rdv = prdata;
            errv = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rd(input string what, input logic [11:0] addr, input logic [31:0] exp);
        begin
            apb(1'b0, addr, 32'h0000_0000);
            check(what, rdv, exp);
        end
    endtask
    // a full frame, then a few clocks for the buffer load to land
    task automatic rx(input logic [8:0] v, input int nb, input int bc);
        begin
            u_uarx_tx_model.send(v, nb, bc);
            repeat (4) @(posedge clock);
        end
    endtask
    // ****
    // main sequence
    // ****
    initial
    begin
        miscompares = 0;
        compares = 0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        for (i = 0; i < 5; i++)
            rd("reset", RST_OFFS[i], 32'h0000_0000);
        apb(1'b1, 12'h01C, 32'h0000_00FF);
        check("slverr", {31'h0, errv}, 32'h0000_0001);
        rd("unmapped", 12'h01C, 32'h0000_0000);
        // rate, enables, then reception on with clocked mode clear
        apb(1'b1, UARX_OFF_DIV, 32'h0000_0001);
        check("slverr", {31'h0, errv}, 32'h0000_0000);
        apb(1'b1, UARX_OFF_IRQ_EN, 32'h0000_0020);
        apb(1'b1, UARX_OFF_CORE, 32'h0000_00C0);
        apb(1'b1, UARX_OFF_CTRL, 32'h0000_0015);
        rx(9'h0A5, 8, BIT_HI);
        check("irq", {31'h0, irq}, 32'h0000_0001);
        rd("flag", UARX_OFF_IRQ_FLAG, 32'h0000_0020);
        rd("stat", UARX_OFF_STAT, 32'h0000_0008);
        rd("data", UARX_OFF_DATA, 32'h0000_00A5);
        rd("flag", UARX_OFF_IRQ_FLAG, 32'h0000_0000);
        check("irq", {31'h0, irq}, 32'h0000_0000);
        // global enable off: flag rises but no interrupt
        apb(1'b1, UARX_OFF_CORE, 32'h0000_0040);
        rx(9'h03C, 8, BIT_HI);
        check("irq", {31'h0, irq}, 32'h0000_0000);
        rd("flag", UARX_OFF_IRQ_FLAG, 32'h0000_0020);
        rd("data", UARX_OFF_DATA, 32'h0000_003C);
        apb(1'b1, UARX_OFF_CORE, 32'h0000_00C0);
        // two characters unread: overrun keeps the first
        rx(9'h011, 8, BIT_HI);
        rx(9'h022, 8, BIT_HI);
        rd("stat", UARX_OFF_STAT, 32'h0000_000C);
        apb(1'b1, UARX_OFF_CTRL, 32'h0000_0011);
        rd("stat", UARX_OFF_STAT, 32'h0000_0008);
        rd("data", UARX_OFF_DATA, 32'h0000_0011);
        // nine-bit characters, ninth set and clear
        apb(1'b1, UARX_OFF_CTRL, 32'h0000_0017);
        rx(9'h13C, 9, BIT_HI);
        rd("stat", UARX_OFF_STAT, 32'h0000_0009);
        rd("data", UARX_OFF_DATA, 32'h0000_003C);
        rx(9'h0C3, 9, BIT_HI);
        rd("stat", UARX_OFF_STAT, 32'h0000_0008);
        rd("data", UARX_OFF_DATA, 32'h0000_00C3);
        // address detect: data discarded, address kept
        apb(1'b1, UARX_OFF_CTRL, 32'h0000_001F);
        rx(9'h055, 9, BIT_HI);
        rd("flag", UARX_OFF_IRQ_FLAG, 32'h0000_0000);
        rx(9'h17E, 9, BIT_HI);
        rd("stat", UARX_OFF_STAT, 32'h0000_0009);
        rd("data", UARX_OFF_DATA, 32'h0000_007E);
        if (rdv[7:0] == 8'h7E)
            apb(1'b1, UARX_OFF_CTRL, 32'h0000_0017);
        rx(9'h011, 9, BIT_HI);
        rd("flag", UARX_OFF_IRQ_FLAG, 32'h0000_0020);
        rd("data", UARX_OFF_DATA, 32'h0000_0011);
        // port off, then continuous receive off: nothing taken
        apb(1'b1, UARX_OFF_CTRL, 32'h0000_0014);
        rx(9'h05A, 8, BIT_HI);
        rd("flag", UARX_OFF_IRQ_FLAG, 32'h0000_0000);
        apb(1'b1, UARX_OFF_CTRL, 32'h0000_0011);
        rx(9'h05A, 8, BIT_HI);
        rd("flag", UARX_OFF_IRQ_FLAG, 32'h0000_0000);
        // clocked-mode select set: receiver stays off
        apb(1'b1, UARX_OFF_CTRL, 32'h0000_0035);
        rx(9'h05A, 8, BIT_HI);
        rd("flag", UARX_OFF_IRQ_FLAG, 32'h0000_0000);
        // low speed at divisor 0 doubles the bit time
        apb(1'b1, UARX_OFF_DIV, 32'h0000_0000);
        apb(1'b1, UARX_OFF_CTRL, 32'h0000_0005);
        rx(9'h096, 8, BIT_LO);
        rd("data", UARX_OFF_DATA, 32'h0000_0096);
        // nine bits into an eight-bit receiver: stop sampled low
        rx(9'h0C3, 9, BIT_LO);
        rd("stat", UARX_OFF_STAT, 32'h0000_000A);
        rd("data", UARX_OFF_DATA, 32'h0000_00C3);
        final_report();
    end
endmodule
`default_nettype wire

// ### uarx_pkg.sv
// package for the asynchronous serial receiver: offsets, fields, reset values
package uarx_pkg;
    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [11:0] UARX_OFF_CTRL = 12'h000;
    localparam logic [11:0] UARX_OFF_STAT = 12'h004;
    localparam logic [11:0] UARX_OFF_DATA = 12'h008;
    localparam logic [11:0] UARX_OFF_DIV = 12'h00C;
    localparam logic [11:0] UARX_OFF_IRQ_FLAG = 12'h010;
    localparam logic [11:0] UARX_OFF_IRQ_EN = 12'h014;
    localparam logic [11:0] UARX_OFF_CORE = 12'h018;
    // ****************************************
    // field positions
    // ****************************************
    localparam int UARX_CTRL_SPE = 0; // serial_port_enable
    localparam int UARX_CTRL_NINE = 1; // nine_bit_receive_enable
    localparam int UARX_CTRL_CRE = 2; // continuous_receive_enable
    localparam int UARX_CTRL_ADE = 3; // address_detect_enable
    localparam int UARX_CTRL_HSS = 4; // baud_high_speed_select
    localparam int UARX_CTRL_SYNC = 5; // clocked-mode select
    localparam int UARX_STAT_NINTH = 0;
    localparam int UARX_STAT_FERR = 1;
    localparam int UARX_STAT_OVERRUN_ERROR_FLAG = 2;
    localparam int UARX_STAT_FULL = 3;
    localparam int UARX_IRQ_RECV = 5; // receive flag / enable position
    localparam int UARX_CORE_PERIPHERAL_IRQ_ENABLE = 6;
    localparam int UARX_CORE_GIE = 7;
    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [7:0] UARX_CTRL_RST = 8'h00;
    localparam logic [7:0] UARX_DIV_RST = 8'h00;
    localparam logic [7:0] UARX_IRQ_RST = 8'h00;
    localparam logic [7:0] UARX_CORE_RST = 8'h00;
    localparam logic [3:0] UARX_OVS_HIGH = 4'hF; // 16 ticks per bit, high speed
    localparam logic [5:0] UARX_PRE_LOW = 6'h03; // x4 prescale for low speed
    localparam logic [3:0] UARX_HALF_BIT = 4'h7;
    // received character handed to the buffer
    typedef struct packed
    {
        logic ninth;
        logic ferr;
        logic [7:0] data;
    } uarx_char_t;
endpackage

// ### uarx_shift.sv
// receive shift register: start detect, oversampled bit capture
`timescale 1ns/100ps
`default_nettype none
module uarx_shift
    import uarx_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic nine,
    input wire logic hss,
    input wire logic [7:0] divisor,
    input wire logic rxd,
    output logic done,
    output uarx_char_t chr
);
    typedef enum logic [2:0]
    {
        UARX_IDLE = 3'b001,
        UARX_START = 3'b010,
        UARX_BITS = 3'b100
    } uarx_state_t;

    uarx_state_t state_reg;
    logic [7:0] div_reg;
    logic [5:0] pre_reg;
    logic [3:0] ovs_reg;
    logic [3:0] cnt_reg;
    logic [9:0] sh_reg;
    logic rx_s1_reg;
    logic rx_s2_reg;
    // tick: divisor+1 clocks, times 4 more in low speed mode
    wire logic div_wrap = (div_reg == divisor);
    wire logic tick = div_wrap && (hss || pre_reg == UARX_PRE_LOW);
    wire logic mid = tick && (ovs_reg == UARX_HALF_BIT);
    wire logic [3:0] last_bit = nine ? 4'h9 : 4'h8;

    // ****************************************
    // line synchroniser and baud ticks
    // ****************************************
    always_ff @(posedge clk)
    begin
        rx_s1_reg <= rst ? 1'b1 : rxd;
        rx_s2_reg <= rst ? 1'b1 : rx_s1_reg;
        div_reg <= (rst || div_wrap || state_reg == UARX_IDLE) ? 8'h00 : div_reg + 8'h01;
        if (rst || state_reg == UARX_IDLE)
            pre_reg <= 6'h00;
        else if (div_wrap)
            pre_reg <= (pre_reg == UARX_PRE_LOW) ? 6'h00 : pre_reg + 6'h01;
        ovs_reg <= (rst || state_reg == UARX_IDLE) ? 4'h0 : (tick ? ovs_reg + 4'h1 : ovs_reg);
    end

    // ****************************************
    // frame state machine
    // ****************************************
    always_ff @(posedge clk)
    begin
        done <= 1'b0;
        if (rst || !run)
        begin
            state_reg <= UARX_IDLE; // idle while disabled
            cnt_reg <= 4'h0;
            sh_reg <= 10'h000;
            chr <= '0;
        end
        else
        begin
            case (state_reg)
                UARX_IDLE:
                    if (!rx_s2_reg)
                        state_reg <= UARX_START;
                UARX_START:
                    if (mid)
                    begin
                        // a glitch shorter than half a bit is ignored
                        state_reg <= rx_s2_reg ? UARX_IDLE : UARX_BITS;
                        cnt_reg <= 4'h0;
                    end
                UARX_BITS:
                    if (mid)
                    begin
                        // a mode change mid-frame still ends the frame here
                        if (cnt_reg >= last_bit)
                        begin
                            // stop bit sampled: hand over the character
                            done <= 1'b1;
                            chr.data <= sh_reg[7:0];
                            chr.ninth <= nine & sh_reg[8];
                            chr.ferr <= ~rx_s2_reg;
                            state_reg <= UARX_IDLE;
                        end
                        else
                        begin
                            sh_reg[cnt_reg] <= rx_s2_reg;
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                default:
                    state_reg <= UARX_IDLE;
            endcase
        end
    end

    wire logic frame_len_ok = (cnt_reg <= last_bit);
    frame_len_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == UARX_BITS |-> frame_len_ok)
        else $error("bit counter ran past frame end");
endmodule
`default_nettype wire

// ### uarx_top.sv
// top of the asynchronous serial receiver with its APB register file
// Contract
// - receiver idle while port enable clear
// - bit rate from divisor and speed select
// - nine-bit enable adds a ninth bit
// - receive only while continuous enable set
// - buffer load sets receive flag
// - interrupt needs flag and all enables
// - status shows errors and ninth bit
// - data read returns low eight bits
// - overrun cleared only by clearing continuous enable
// - address detect buffers only ninth-set characters
// - ninth bit reads one in address mode
// - address detect clear buffers every character
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module uarx_top
    import uarx_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RXD,
    output logic IRQ
);
    logic [7:0] ctrl_reg;
    logic [7:0] div_reg;
    logic [7:0] ien_reg;
    logic [7:0] core_reg;
    logic full_reg;
    logic overrun_error_flag_reg;
    logic irq_flag_reg;
    logic pop_ok_reg;
    uarx_char_t buf_reg;
    logic done;
    uarx_char_t chr;

    // ****************************************
    // bus decode
    // ****************************************
    wire logic acc = PSEL && PENABLE && PREADY;
    wire logic wr = acc && PWRITE;
    wire logic rd = acc && !PWRITE;
    wire logic hit_ctrl = (PADDR == UARX_OFF_CTRL);
    wire logic hit_stat = (PADDR == UARX_OFF_STAT);
    wire logic hit_data = (PADDR == UARX_OFF_DATA);
    wire logic hit_div = (PADDR == UARX_OFF_DIV);
    wire logic hit_flag = (PADDR == UARX_OFF_IRQ_FLAG);
    wire logic hit_ien = (PADDR == UARX_OFF_IRQ_EN);
    wire logic hit_core = (PADDR == UARX_OFF_CORE);
    wire logic mapped = hit_ctrl | hit_stat | hit_data | hit_div | hit_flag | hit_ien | hit_core;

    // ****************************************
    // receiver control view
    // ****************************************
    // clocked-mode bit set means the async receiver stays off
    wire logic port_on = ctrl_reg[UARX_CTRL_SPE] && !ctrl_reg[UARX_CTRL_SYNC];
    wire logic cre = ctrl_reg[UARX_CTRL_CRE];
    wire logic nine = ctrl_reg[UARX_CTRL_NINE];
    wire logic address_detect_enable = ctrl_reg[UARX_CTRL_ADE] && nine;
    wire logic run = port_on && cre;
    // address mode drops characters whose ninth bit is clear
    wire logic accept = done && (!address_detect_enable || chr.ninth);
    wire logic load = accept && !full_reg && !overrun_error_flag_reg;
    wire logic overrun = accept && full_reg;
    // a read that found the buffer empty must not pop a character loaded meanwhile
    wire logic pop = rd && hit_data && pop_ok_reg;
    wire logic cre_clear = wr && hit_ctrl && !PWDATA[UARX_CTRL_CRE];

    uarx_shift u_shift
    (
        .clk(CLOCK),
        .rst(SYS_RST),
        .run(run),
        .nine(nine),
        .hss(ctrl_reg[UARX_CTRL_HSS]),
        .divisor(div_reg),
        .rxd(RXD),
        .done(done),
        .chr(chr)
    );

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            ctrl_reg <= UARX_CTRL_RST;
            div_reg <= UARX_DIV_RST;
            ien_reg <= UARX_IRQ_RST;
            core_reg <= UARX_CORE_RST;
        end
        else
        begin
            if (wr && hit_ctrl)
                ctrl_reg <= {2'b00, PWDATA[5:0]};
            if (wr && hit_div)
                div_reg <= PWDATA[7:0];
            if (wr && hit_ien)
                ien_reg <= PWDATA[7:0];
            if (wr && hit_core)
                core_reg <= PWDATA[7:0];
        end
    end

    // ****************************************
    // receive buffer, overrun and flag
    // ****************************************
    // one-deep buffer; load wins over a same-cycle pop
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            full_reg <= 1'b0;
            buf_reg <= '0;
            overrun_error_flag_reg <= 1'b0;
            pop_ok_reg <= 1'b0;
        end
        else
        begin
            pop_ok_reg <= full_reg; // buffer state when read data is latched
            if (load)
            begin
                full_reg <= 1'b1;
                buf_reg <= chr;
                buf_reg.ninth <= chr.ninth | address_detect_enable;
            end
            else if (pop)
                full_reg <= 1'b0;
            if (overrun)
                overrun_error_flag_reg <= 1'b1;
            else if (cre_clear || !cre)
                overrun_error_flag_reg <= 1'b0;
        end
    end

    // receive flag mirrors buffer occupancy, sticky until emptied
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            irq_flag_reg <= 1'b0;
        else if (load)
            irq_flag_reg <= 1'b1;
        else if (pop || (wr && hit_flag && PWDATA[UARX_IRQ_RECV] && !full_reg))
            irq_flag_reg <= 1'b0;
    end

    // ****************************************
    // interrupt and read data
    // ****************************************
    wire logic irq_next = irq_flag_reg && ien_reg[UARX_IRQ_RECV]
        && core_reg[UARX_CORE_PERIPHERAL_IRQ_ENABLE] && core_reg[UARX_CORE_GIE];
    wire logic [7:0] stat_view = {4'h0, full_reg, overrun_error_flag_reg, buf_reg.ferr, buf_reg.ninth};
    wire logic [7:0] flag_view = {2'b00, irq_flag_reg, 5'b00000};
    wire logic [7:0] rd_sel =
        hit_ctrl ? ctrl_reg :
        hit_stat ? stat_view :
        hit_data ? buf_reg.data :
        hit_div ? div_reg :
        hit_flag ? flag_view :
        hit_ien ? ien_reg :
        hit_core ? core_reg : 8'h00;

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            // one wait state: ready rises in the second access cycle
            PREADY <= PSEL && PENABLE && !PREADY;
            PRDATA <= {24'h00_0000, rd_sel};
            PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
            IRQ <= irq_next;
        end
    end

    // ****************************************
    // bus checks
    // ****************************************
    // ready answers one access cycle, once
    ready_pulse_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

    ready_access_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        PREADY |-> $past(PSEL) && $past(PENABLE))
        else $error("ready without an access cycle");

    slverr_ready_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        PSLVERR |-> PREADY)
        else $error("slave error outside ready");

    slverr_map_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        PREADY |-> (PSLVERR == !$past(mapped)))
        else $error("slave error does not match decode");

    // ****************************************
    // receive checks
    // ****************************************
    // buffer, flag and interrupt line
    flag_on_load_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        load |=> irq_flag_reg && full_reg)
        else $error("receive flag missing after buffer load");

    flag_full_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        irq_flag_reg == full_reg)
        else $error("receive flag differs from buffer state");

    pop_clear_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        pop && !load |=> !full_reg && !irq_flag_reg)
        else $error("data read did not empty buffer");

    irq_gating_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        IRQ |-> $past(irq_flag_reg) && $past(ien_reg[UARX_IRQ_RECV]))
        else $error("interrupt without flag and enable");

    irq_rise_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        irq_next |=> IRQ)
        else $error("interrupt missing with flag and enables set");

    irq_fall_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !irq_next |=> !IRQ)
        else $error("interrupt high without its conditions");

    // overrun handling
    overrun_set_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        overrun |=> overrun_error_flag_reg)
        else $error("overrun not flagged");

    overrun_block_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        overrun_error_flag_reg |-> !load)
        else $error("buffer loaded during overrun");

    overrun_hold_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        overrun_error_flag_reg && cre && !cre_clear |=> overrun_error_flag_reg)
        else $error("overrun cleared while receive enabled");

    overrun_error_flag_drop_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !cre && !overrun |=> !overrun_error_flag_reg)
        else $error("overrun kept with receive disabled");

    cre_clear_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        cre_clear && !overrun |=> !overrun_error_flag_reg)
        else $error("overrun kept after receive enable write");

    // enables
    run_done_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !run |=> !done)
        else $error("character completed while receive off");

    idle_off_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !port_on |-> !load)
        else $error("load while port disabled");

    sync_off_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ctrl_reg[UARX_CTRL_SYNC] |-> !run)
        else $error("receiver running in clocked mode");

    // address detection
    address_detect_enable_nine_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        address_detect_enable |-> nine)
        else $error("address detect without nine-bit mode");

    addr_filter_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        done && address_detect_enable && !chr.ninth |=> $stable(buf_reg))
        else $error("address mode buffered a data character");

    addr_drop_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        done && address_detect_enable && !chr.ninth && !irq_flag_reg |=> !irq_flag_reg)
        else $error("address mode flagged a data character");

    addr_ninth_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        load && address_detect_enable |=> buf_reg.ninth)
        else $error("ninth bit not one in address mode");

    // buffered character contents
    ninth_eight_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        load && !nine && !$past(nine) |=> !buf_reg.ninth)
        else $error("ninth bit set in eight-bit mode");

    data_copy_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        load |=> buf_reg.data == $past(chr.data))
        else $error("buffered data differs from received character");

    ferr_copy_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        load |=> buf_reg.ferr == $past(chr.ferr))
        else $error("framing error not kept with character");
endmodule
`default_nettype wire

// ### uarx_tx_model.sv
// remote serial transmitter model that drives the receive line
`timescale 1ns/100ps
`default_nettype none
module uarx_tx_model
(
    input wire logic clk,
    output logic line
);
    // ****
    // frame sender
    // ****
    // idle is mark; the model drives the line high outside frames
    initial
    begin
        line = 1'b1;
    end
    // start low, nb data bits lsb first, stop high, each bclks clocks long
    task automatic send(input logic [8:0] val, input int nb, input int bclks);
        int i;
        begin
            @(posedge clk);
            line <= 1'b0;
            repeat (bclks) @(posedge clk);
            for (i = 0; i < nb; i++)
            begin
                line <= val[i];
                repeat (bclks) @(posedge clk);
            end
            line <= 1'b1;
            repeat (bclks) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire
